// ===== pkg/lcpe_consts.vh
`ifndef LCPE_CONSTS_VH
`define LCPE_CONSTS_VH

// Clock rate and the timing figures that the retransmission timer needs.
`define LCPE_CLK_HZ        25000000
`define LCPE_TICK_US       1000
`define LCPE_TICK_CYC      (`LCPE_CLK_HZ / 1000000 * `LCPE_TICK_US)
`define LCPE_T01_MS        1000
`define LCPE_T01_TICKS     (`LCPE_T01_MS * 1000 / `LCPE_TICK_US)

// Message layout: octet positions and the full message length.
`define LCPE_MSG_LEN       4'h7
`define LCPE_HDR_LEN       4'h4
`define LCPE_POS_PD        3'h0
`define LCPE_POS_ADR_HI    3'h1
`define LCPE_POS_ADR_LO    3'h2
`define LCPE_POS_TYPE      3'h3
`define LCPE_POS_IE_ID     3'h4
`define LCPE_POS_IE_LEN    3'h5
`define LCPE_POS_FUNC      3'h6

// Octet codings.
`define LCPE_PROT_DISC     8'h01
`define LCPE_ADR_HI        8'h00
`define LCPE_TYPE_LC       8'h30
`define LCPE_TYPE_ACK      8'h31
`define LCPE_IE_ID         8'h30
`define LCPE_IE_LEN        8'h01
`define LCPE_EXT_BIT       7

// Function codes; codes above the last one are reserved.
`define LCPE_IDENTITY_REQUEST_CODE        7'h00
`define LCPE_IDENTITY_ACK_CODE            7'h01
`define LCPE_IDENTITY_RELEASE_CODE        7'h02
`define LCPE_IDENTITY_REJECT_CODE         7'h03
`define LCPE_LINK_UNBLOCK_CODE            7'h04
`define LCPE_LINK_BLOCK_CODE              7'h05
`define LCPE_DEFERRED_BLOCK_REQUEST_CODE  7'h06
`define LCPE_IMMEDIATE_BLOCK_REQUEST_CODE 7'h07

// Service states, one-hot.
`define LCPE_S_OOS         3'h1
`define LCPE_S_INS         3'h2
`define LCPE_S_AWT         3'h4

`endif

// ===== rtl/lcpe_entity.v
// Overview of operation
// (R01) Address: zero octet, then link identifier octet.
// (R02) Function element: identifier, length, extended code.
// (R03) Function codes zero to seven; others reserved.
// (R04) Out of service at start and stop.
// (R05) Start moves out of service to in service.
// (R06) Out of service: messages, events raise error.
// (R07) Stop returns service or awaiting to out.
// (R08) In service: acknowledge message, pass function up.
// (R09) In service event: send, start timer, await.
// (R10) Awaiting: still acknowledge and forward peer messages.
// (R11) Acknowledgement while awaiting: stop timer, in service.
// (R12) Events while awaiting are stored, not lost.
// (R13) First timeout: resend message, restart timer.
// (R14) Second timeout: report error, back in service.
// (R15) Event store is first-in first-out, one active.
// (R16) One entity per link, selected by address.
// (R17) Outgoing messages go to the data link.
// (R18) Shorter than four octets: discard, protocol error.
// (R19) Header checks in fixed order before processing.
// (R20) No state change during checks; only clean proceed.
// (R21) Wrong discriminator: discard, protocol error.
// (R22) Retransmission timeout one second, ten percent tolerance.
// (R23) Bad or foreign address: discard, protocol error.
// (R24) Timer counts prescaled tick; expiry count kept.
`timescale 1ns/1ps
`include "lcpe_consts.vh"

module lcpe_entity #(
  parameter TICK_CYCLES = `LCPE_TICK_CYC,
  parameter T01_TICKS   = `LCPE_T01_TICKS,
  parameter FIFO_DEPTH  = 4,
  parameter FIFO_AW     = 2
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire [7:0] link_address,
  input  wire       start_traffic_request,
  input  wire       stop_traffic_request,
  input  wire       function_event,
  input  wire [6:0] function_event_code,
  output wire       function_event_ready,
  input  wire       rx_valid,
  input  wire [7:0] rx_data,
  input  wire       rx_last,
  output wire       rx_ready,
  output wire       tx_valid,
  output reg  [7:0] tx_data_ff,
  output wire       tx_last,
  input  wire       tx_ready,
  output reg        ind_valid_ff,
  output reg  [6:0] ind_code_ff,
  output reg  [7:0] ind_address_ff,
  output reg        management_error_report_ff,
  output reg        protocol_error_ff,
  output reg  [2:0] state_ff
);

  // Builds one octet of an outgoing message from its position.
  function [7:0] lcpe_octet;
    input [2:0] idx;
    input [7:0] adr;
    input [7:0] typ;
    input [6:0] code;
    begin
      case (idx)
        // (R01) discriminator, address and type octets
        `LCPE_POS_PD:     lcpe_octet = `LCPE_PROT_DISC;
        `LCPE_POS_ADR_HI: lcpe_octet = `LCPE_ADR_HI;
        `LCPE_POS_ADR_LO: lcpe_octet = adr;
        `LCPE_POS_TYPE:   lcpe_octet = typ;
        // (R02) function element
        `LCPE_POS_IE_ID:  lcpe_octet = `LCPE_IE_ID;
        `LCPE_POS_IE_LEN: lcpe_octet = `LCPE_IE_LEN;
        default:          lcpe_octet = {1'b1, code};
      endcase
    end
  endfunction

  // Receive buffer and length, one entry per octet position.
  reg  [7:0] rx_buf_ff [0:6];
  reg  [3:0] rx_cnt_ff;           // Octets gathered so far, saturating.
  reg        chk_ff;              // Complete message waits for checks.
  reg        rx_lc_ff;            // Clean link control message pending.
  reg        rx_ack_ff;           // Clean acknowledgement pending.
  reg  [6:0] rx_code_ff;          // Function of the pending message.
  // Event store.
  reg  [6:0] fifo_mem_ff [0:FIFO_DEPTH-1];
  reg  [FIFO_AW:0] wr_ptr_ff;
  reg  [FIFO_AW:0] rd_ptr_ff;
  // Transmitter.
  reg        tx_busy_ff;          // A message is being handed out.
  reg  [2:0] tx_idx_ff;           // Position of the octet on tx_data_ff.
  reg  [7:0] tx_type_ff;          // Message type being sent.
  reg  [6:0] tx_code_ff;          // Function being sent.
  reg  [6:0] lc_code_ff;          // Function of the outstanding message.
  // Retransmission timer.
  reg  [31:0] pre_ff;             // Prescaler towards the next tick.
  reg  [31:0] tmr_ff;             // Ticks since the timer was started.
  reg        tmr_run_ff;          // Timer running.
  reg        tmo_ff;              // Expiry waiting for the state machine.
  reg        expired_ff;          // One expiry already seen this episode.

  wire       fifo_empty = (wr_ptr_ff == rd_ptr_ff);
  wire       fifo_full  = (wr_ptr_ff[FIFO_AW] != rd_ptr_ff[FIFO_AW]) &&
                          (wr_ptr_ff[FIFO_AW-1:0] == rd_ptr_ff[FIFO_AW-1:0]);
  wire [6:0] fifo_head  = fifo_mem_ff[rd_ptr_ff[FIFO_AW-1:0]];
  wire       push       = function_event && !fifo_full;
  wire       tx_fire    = tx_busy_ff && tx_ready;
  wire       tick       = (pre_ff == TICK_CYCLES - 1);

  // The receive side is held off while a message waits to be used, so
  // a slow transmitter back-pressures the data link instead of dropping.
  assign rx_ready  = !chk_ff && !rx_lc_ff && !rx_ack_ff;
  assign function_event_ready = !fifo_full;
  // (R17) handed to link
  assign tx_valid  = tx_busy_ff;
  assign tx_last   = tx_busy_ff && (tx_idx_ff == `LCPE_POS_FUNC);

  // Checks on a complete message, all evaluated together; the first
  // failing one decides, but every failure gives the same report.
  reg        bad_msg;
  always @* begin
    bad_msg = 1'b0;
    // (R18) too short
    if (rx_cnt_ff < `LCPE_HDR_LEN)
      bad_msg = 1'b1;
    // (R21) discriminator check
    else if (rx_buf_ff[0] != `LCPE_PROT_DISC)
      bad_msg = 1'b1;
    // (R16) (R23) address check
    else if (rx_buf_ff[1] != `LCPE_ADR_HI || rx_buf_ff[2] != link_address)
      bad_msg = 1'b1;
    // (R19) message type next
    else if (rx_buf_ff[3] != `LCPE_TYPE_LC &&
             rx_buf_ff[3] != `LCPE_TYPE_ACK)
      bad_msg = 1'b1;
    // (R02) element layout
    else if (rx_cnt_ff != `LCPE_MSG_LEN || rx_buf_ff[4] != `LCPE_IE_ID ||
             rx_buf_ff[5] != `LCPE_IE_LEN ||
             !rx_buf_ff[6][`LCPE_EXT_BIT])
      bad_msg = 1'b1;
    // (R03) reserved codes
    else if (rx_buf_ff[6][6:0] > `LCPE_IMMEDIATE_BLOCK_REQUEST_CODE)
      bad_msg = 1'b1;
  end

  // Gathers octets, runs the checks and keeps a clean message pending.
  // The state register is not touched here at all.
  always @(posedge clk) begin
    if (!rst_b) begin
      rx_cnt_ff         <= 4'h0;
      chk_ff            <= 1'b0;
      protocol_error_ff <= 1'b0;
      rx_code_ff        <= 7'h00;
    end else begin
      protocol_error_ff <= 1'b0;
      if (rx_valid && rx_ready) begin
        if (rx_cnt_ff < `LCPE_MSG_LEN)
          rx_buf_ff[rx_cnt_ff[2:0]] <= rx_data;
        // Overlong messages keep counting so the length check fails.
        if (rx_cnt_ff != 4'hf)
          rx_cnt_ff <= rx_cnt_ff + 4'h1;
        chk_ff <= rx_last;
      end
      if (chk_ff) begin
        // (R20) checks before state
        chk_ff     <= 1'b0;
        rx_cnt_ff  <= 4'h0;
        rx_code_ff <= rx_buf_ff[6][6:0];
        if (bad_msg)
          protocol_error_ff <= 1'b1;
      end
    end
  end

  // Stores local events in arrival order; the state machine pops them.
  always @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_ff <= {(FIFO_AW+1){1'b0}};
    end else if (push) begin
      // (R12) store while busy
      fifo_mem_ff[wr_ptr_ff[FIFO_AW-1:0]] <= function_event_code;
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
    end
  end

  // Prescaler for the retransmission timer. The timer itself, in the state machine block, freezes at expiry and
  // leaves a flag, so an expiry is never lost while the link is busy.
  always @(posedge clk) begin
    if (!rst_b) begin
      pre_ff <= 32'h0000_0000;
    end else begin
      // (R24) prescaled tick
      pre_ff <= tick ? 32'h0000_0000 : pre_ff + 32'h0000_0001;
    end
  end

  // Service state machine, transmitter and timer control. Priority is
  // stop, start, received message, expiry, then the event store.
  always @(posedge clk) begin
    if (!rst_b) begin
      // (R04) out at start
      state_ff                   <= `LCPE_S_OOS;
      rx_lc_ff                   <= 1'b0;
      rx_ack_ff                  <= 1'b0;
      rd_ptr_ff                  <= {(FIFO_AW+1){1'b0}};
      tx_busy_ff                 <= 1'b0;
      tx_idx_ff                  <= 3'h0;
      tx_data_ff                 <= 8'h00;
      lc_code_ff                 <= 7'h00;
      tmr_ff                     <= 32'h0000_0000;
      tmr_run_ff                 <= 1'b0;
      tmo_ff                     <= 1'b0;
      expired_ff                 <= 1'b0;
      ind_valid_ff               <= 1'b0;
      ind_code_ff                <= 7'h00;
      ind_address_ff             <= 8'h00;
      management_error_report_ff <= 1'b0;
    end else begin
      ind_valid_ff               <= 1'b0;
      management_error_report_ff <= 1'b0;
      if (chk_ff && !bad_msg) begin
        rx_lc_ff  <= (rx_buf_ff[3] == `LCPE_TYPE_LC);
        rx_ack_ff <= (rx_buf_ff[3] == `LCPE_TYPE_ACK);
      end
      // (R22) one second timeout
      if (tmr_run_ff && tick) begin
        if (tmr_ff == T01_TICKS - 1) begin
          tmr_run_ff <= 1'b0;
          tmo_ff     <= 1'b1;
        end else
          tmr_ff <= tmr_ff + 32'h0000_0001;
      end
      // Transmitter advances one octet per accepted handshake.
      if (tx_fire) begin
        tx_idx_ff  <= tx_idx_ff + 3'h1;
        tx_data_ff <= lcpe_octet(tx_idx_ff + 3'h1, link_address,
                                 tx_type_ff, tx_code_ff);
        // The index returns to zero so the next message starts cleanly.
        if (tx_idx_ff == `LCPE_POS_FUNC) begin
          tx_busy_ff <= 1'b0;
          tx_idx_ff  <= 3'h0;
        end
      end
      if (stop_traffic_request) begin
        // (R07) stop traffic
        state_ff   <= `LCPE_S_OOS;
        tmr_run_ff <= 1'b0;
        tmo_ff     <= 1'b0;
      end else if (start_traffic_request) begin
        // (R05) start traffic
        if (state_ff == `LCPE_S_OOS)
          state_ff <= `LCPE_S_INS;
      end else begin
        case (state_ff)
          `LCPE_S_OOS: begin
            // (R06) error, no change
            if (rx_lc_ff || rx_ack_ff) begin
              rx_lc_ff                   <= 1'b0;
              rx_ack_ff                  <= 1'b0;
              management_error_report_ff <= 1'b1;
            end else if (!fifo_empty) begin
              rd_ptr_ff                  <= rd_ptr_ff + 1'b1;
              management_error_report_ff <= 1'b1;
            end
          end
          `LCPE_S_INS: begin
            if (rx_ack_ff) begin
              // An acknowledgement nobody awaits is dropped quietly.
              rx_ack_ff <= 1'b0;
            end else if (rx_lc_ff && !tx_busy_ff) begin
              // (R08) acknowledge and forward
              rx_lc_ff       <= 1'b0;
              tx_busy_ff     <= 1'b1;
              tx_type_ff     <= `LCPE_TYPE_ACK;
              tx_code_ff     <= rx_code_ff;
              tx_data_ff     <= `LCPE_PROT_DISC;
              ind_valid_ff   <= 1'b1;
              ind_code_ff    <= rx_code_ff;
              ind_address_ff <= rx_buf_ff[2];
            end else if (!rx_lc_ff && !fifo_empty && !tx_busy_ff) begin
              // (R09) send and await
              // (R15) next stored event
              rd_ptr_ff  <= rd_ptr_ff + 1'b1;
              tx_busy_ff <= 1'b1;
              tx_type_ff <= `LCPE_TYPE_LC;
              tx_code_ff <= fifo_head;
              tx_data_ff <= `LCPE_PROT_DISC;
              lc_code_ff <= fifo_head;
              tmr_ff     <= 32'h0000_0000;
              tmr_run_ff <= 1'b1;
              tmo_ff     <= 1'b0;
              expired_ff <= 1'b0;
              state_ff   <= `LCPE_S_AWT;
            end
          end
          `LCPE_S_AWT: begin
            if (rx_ack_ff) begin
              // (R11) stop timer
              rx_ack_ff  <= 1'b0;
              tmr_run_ff <= 1'b0;
              tmo_ff     <= 1'b0;
              state_ff   <= `LCPE_S_INS;
            end else if (rx_lc_ff && !tx_busy_ff) begin
              // (R10) acknowledge while awaiting
              rx_lc_ff       <= 1'b0;
              tx_busy_ff     <= 1'b1;
              tx_type_ff     <= `LCPE_TYPE_ACK;
              tx_code_ff     <= rx_code_ff;
              tx_data_ff     <= `LCPE_PROT_DISC;
              ind_valid_ff   <= 1'b1;
              ind_code_ff    <= rx_code_ff;
              ind_address_ff <= rx_buf_ff[2];
            end else if (tmo_ff && expired_ff) begin
              // (R14) second expiry
              tmo_ff                     <= 1'b0;
              management_error_report_ff <= 1'b1;
              state_ff                   <= `LCPE_S_INS;
            end else if (tmo_ff && !tx_busy_ff) begin
              // (R13) resend and restart
              tmo_ff     <= 1'b0;
              expired_ff <= 1'b1;
              tx_busy_ff <= 1'b1;
              tx_type_ff <= `LCPE_TYPE_LC;
              tx_code_ff <= lc_code_ff;
              tx_data_ff <= `LCPE_PROT_DISC;
              tmr_ff     <= 32'h0000_0000;
              tmr_run_ff <= 1'b1;
            end
          end
          default: state_ff <= `LCPE_S_OOS;
        endcase
      end
    end
  end

endmodule // lcpe_entity

// ===== test/lcpe_chk.sv
`timescale 1ns/1ps
`include "lcpe_consts.vh"
// Port checker for the link entity; one clock domain throughout.
module lcpe_chk (
  input wire       clk,
  input wire       rst_b,
  input wire [7:0] link_address,
  input wire       start_traffic_request,
  input wire       stop_traffic_request,
  input wire       rx_valid,
  input wire       rx_last,
  input wire       rx_ready,
  input wire       tx_valid,
  input wire [7:0] tx_data_ff,
  input wire       tx_ready,
  input wire       ind_valid_ff,
  input wire [7:0] ind_address_ff,
  input wire       protocol_error_ff,
  input wire [2:0] state_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_start;
    state_ff == `LCPE_S_OOS && start_traffic_request &&
      !stop_traffic_request |=> state_ff == `LCPE_S_INS;
  endproperty
  a_start: assert property (p_start) else $error("start ignored");
  property p_oos_hold;
    state_ff == `LCPE_S_OOS && !start_traffic_request
      |=> state_ff == `LCPE_S_OOS;
  endproperty
  a_oos_hold: assert property (p_oos_hold) else $error("left idle");
  property p_stop;
    stop_traffic_request |=> state_ff == `LCPE_S_OOS;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  property p_awt;
    $rose(state_ff[2]) |-> tx_valid && tx_data_ff == `LCPE_PROT_DISC;
  endproperty
  a_awt: assert property (p_awt) else $error("await without send");
  property p_ind;
    ind_valid_ff |-> ind_address_ff == link_address;
  endproperty
  a_ind: assert property (p_ind) else $error("wrong address up");
  property p_perr;
    protocol_error_ff |-> $past(rx_valid && rx_ready && rx_last, 2);
  endproperty
  a_perr: assert property (p_perr) else $error("stray error");
  // checks hold receive; a discarded message frees it a cycle early.
  property p_rx_hold;
    rx_valid && rx_ready && rx_last |=> !rx_ready ##1
      (!rx_ready || protocol_error_ff);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx not held");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data_ff);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx dropped");
endmodule // lcpe_chk

// ===== test/lcpe_peer.sv
`timescale 1ns/1ps
// Peer entity on the data link: sends framed octets, collects replies.
module lcpe_peer (
  input  wire       clk,
  input  wire       slow,
  input  wire       tx_valid,
  input  wire [7:0] tx_data,
  input  wire       tx_last,
  output reg        tx_ready,
  output reg        rx_valid,
  output reg  [7:0] rx_data,
  output reg        rx_last,
  input  wire       rx_ready
);
  reg     [55:0] sh;    // Octets of the reply being assembled.
  reg     [55:0] got;   // Last complete reply.
  integer        n_msg; // Number of complete replies.
  initial begin
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    sh = 56'h0;
    got = 56'h0;
    n_msg = 0;
  end
  // A slow peer stalls every other cycle to exercise holding.
  always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      sh = {sh[47:0], tx_data};
      if (tx_last) begin
        got = sh;
        n_msg = n_msg + 1;
      end
    end
  end
  task send(input [55:0] m, input [3:0] n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data = m[55 - 8 * i -: 8];
        rx_last = (i == n - 1);
        while (!rx_ready) @(negedge clk);
        @(posedge clk);
      end
      @(negedge clk);
      // Released data shows the inverse so no stale value passes.
      rx_valid = 1'b0;
      rx_data = ~rx_data;
      rx_last = 1'b0;
    end
  endtask
endmodule // lcpe_peer

// ===== test/tb_top.sv
`timescale 1ns/1ps
`include "lcpe_consts.vh"
// Bench: drives management inputs and the peer, judges the replies.
module tb_top;
  localparam [7:0] ADR = 8'h2a; // Identifier of this link.
  reg        clk, rst_b, start, stop, fe, slow;
  reg  [6:0] fe_code;
  wire       fe_rdy, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  wire [7:0] rx_data, tx_data, ind_adr;
  wire [6:0] ind_code;
  wire       ind_v, merr, perr;
  wire [2:0] state;
  integer    failures, n_tests, cyc, n_ind, n_merr, n_perr, k, n0, m;
  lcpe_entity #(.TICK_CYCLES(4), .T01_TICKS(25)) dut (.clk(clk),
    .rst_b(rst_b), .link_address(ADR), .start_traffic_request(start),
    .stop_traffic_request(stop), .function_event(fe),
    .function_event_code(fe_code), .function_event_ready(fe_rdy),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data_ff(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .ind_valid_ff(ind_v),
    .ind_code_ff(ind_code), .ind_address_ff(ind_adr),
    .management_error_report_ff(merr), .protocol_error_ff(perr),
    .state_ff(state));
  lcpe_peer peer (.clk(clk), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_ready(rx_ready));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Pulses are counted so that tests need not catch the exact cycle.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (ind_v === 1'b1) n_ind = n_ind + 1;
    if (merr === 1'b1) n_merr = n_merr + 1;
    if (perr === 1'b1) n_perr = n_perr + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      results;
    end
  end
  task chk(input [55:0] got, input [55:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  function [55:0] mk(input [7:0] pd, adr, typ, input [6:0] c);
    mk = {pd, `LCPE_ADR_HI, adr, typ, `LCPE_IE_ID, `LCPE_IE_LEN, 1'b1, c};
  endfunction
  function [55:0] lc(input [7:0] typ, input [6:0] c);
    lc = mk(`LCPE_PROT_DISC, ADR, typ, c);
  endfunction
  task mg(input s, input p);
    begin
      @(negedge clk);
      start = s;
      stop = p;
      @(negedge clk);
      start = 1'b0;
      stop = 1'b0;
    end
  endtask
  task ev(input [6:0] c);
    begin
      @(negedge clk);
      fe = 1'b1;
      fe_code = c;
      while (!fe_rdy) @(negedge clk);
      @(negedge clk);
      fe = 1'b0;
    end
  endtask
  task wait_msg(input integer n);
    for (k = 0; k < 400 && peer.n_msg < n; k = k + 1) @(negedge clk);
  endtask
  task t_oos;
    begin
      chk(state, `LCPE_S_OOS);
      chk({rx_ready, fe_rdy, tx_valid}, 3'h6);
      m = n_merr;
      peer.send(lc(`LCPE_TYPE_LC, 7'h01), 7);
      repeat (6) @(negedge clk);
      chk(n_merr, m + 1);
      ev(7'h03);
      repeat (3) @(negedge clk);
      chk(n_merr, m + 2);
      chk({state, 8'(peer.n_msg)}, {`LCPE_S_OOS, 8'h00});
      $display("test oos done");
    end
  endtask
  task t_start;
    begin
      mg(1'b1, 1'b0);
      chk(state, `LCPE_S_INS);
      mg(1'b1, 1'b0);
      chk(state, `LCPE_S_INS);
      $display("test start done");
    end
  endtask
  task t_rx;
    begin
      for (m = 0; m < 8; m = m + 1) begin
        slow = m[0];
        n0 = peer.n_msg;
        peer.send(lc(`LCPE_TYPE_LC, m[6:0]), 7);
        wait_msg(n0 + 1);
        chk(peer.got, lc(`LCPE_TYPE_ACK, m[6:0]));
        chk({n_ind, ind_adr, ind_code}, {n0 + 1, ADR, m[6:0]});
      end
      slow = 1'b0;
      $display("test receive done");
    end
  endtask
  task t_bad;
    begin
      for (m = 0; m < 5; m = m + 1) begin
        n0 = n_perr;
        k = n_ind;
        if (m == 0) peer.send(lc(`LCPE_TYPE_LC, 7'h04), 3);
        if (m == 1) peer.send(mk(8'h02, ADR, `LCPE_TYPE_LC, 7'h04), 7);
        if (m == 2) peer.send(mk(8'h01, ADR ^ 8'h01, 8'h30, 7'h04), 7);
        if (m == 3) peer.send(lc(`LCPE_TYPE_LC, 7'h08), 7);
        if (m == 4) peer.send(lc(8'h32, 7'h04), 7);
        repeat (4) @(negedge clk);
        chk(n_perr, n0 + 1);
        chk({n_ind, state}, {k, `LCPE_S_INS});
      end
      $display("test bad done");
    end
  endtask
  task t_event;
    begin
      n0 = peer.n_msg;
      ev(7'h05);
      wait_msg(n0 + 1);
      chk({peer.got, state}, {lc(`LCPE_TYPE_LC, 7'h05), `LCPE_S_AWT});
      ev(7'h06);
      peer.send(lc(`LCPE_TYPE_LC, 7'h02), 7);
      wait_msg(n0 + 2);
      chk({peer.got, state}, {lc(`LCPE_TYPE_ACK, 7'h02), `LCPE_S_AWT});
      peer.send(lc(`LCPE_TYPE_ACK, 7'h05), 7);
      wait_msg(n0 + 3);
      chk(peer.got, lc(`LCPE_TYPE_LC, 7'h06));
      wait_msg(n0 + 4);
      chk(peer.got, lc(`LCPE_TYPE_LC, 7'h06));
      m = n_merr;
      for (k = 0; k < 400 && n_merr == m; k = k + 1) @(negedge clk);
      chk({n_merr, state}, {m + 1, `LCPE_S_INS});
      chk(peer.n_msg, n0 + 4);
      $display("test event done");
    end
  endtask
  task t_stop;
    begin
      n0 = peer.n_msg;
      ev(7'h07);
      wait_msg(n0 + 1);
      mg(1'b1, 1'b1);
      chk(state, `LCPE_S_OOS);
      $display("test stop done");
    end
  endtask
  task results;
    begin
      $display("checks=%0d failures=%0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    {rst_b, start, stop, fe, slow, fe_code} = 12'h0;
    {failures, n_tests, cyc, n_ind, n_merr, n_perr} = 192'h0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    t_oos;
    t_start;
    t_rx;
    t_bad;
    t_event;
    t_stop;
    results;
  end
endmodule // tb_top
bind lcpe_entity lcpe_chk u_chk (.clk(clk), .rst_b(rst_b),
  .link_address(link_address), .start_traffic_request(start_traffic_request),
  .stop_traffic_request(stop_traffic_request), .rx_valid(rx_valid),
  .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_data_ff(tx_data_ff), .tx_ready(tx_ready), .ind_valid_ff(ind_valid_ff),
  .ind_address_ff(ind_address_ff), .protocol_error_ff(protocol_error_ff),
  .state_ff(state_ff));
